// [inc/spm_pkg.sv]
// constants and types shared by the multi-width serial pin function mux
// assumes a 250 MHz system clock; all pin inputs arrive asynchronously
`default_nettype none
package spm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned T_RP_NS = 100;
    localparam int unsigned RP_CYC_RAW = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RP_CYC = (RP_CYC_RAW < 1) ? 1 : RP_CYC_RAW;

    localparam int unsigned CFG1_QUAD_BIT = 1;
    localparam int unsigned CFG2_FOUR_WIRE_BIT = 3;
    localparam int unsigned CFG2_RST_EN_BIT = 7;
    localparam int unsigned STAT1_PROTECT0_BIT = 7;

    // synchronised pin vector layout
    localparam int unsigned PIN_W = 7;
    localparam int unsigned PIN_SCK = 4;
    localparam int unsigned PIN_CS_N = 5;
    localparam int unsigned PIN_RST_N = 6;
    localparam logic [PIN_W-1:0] PIN_IDLE = 7'h6F;

    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hF;

    typedef enum logic [1:0] {
        SPM_W_SINGLE = 2'h0,
        SPM_W_DUAL = 2'h1,
        SPM_W_QUAD = 2'h2
    } spm_width_t;

    typedef enum logic [2:0] {
        SPM_ST_RESET = 3'h1,
        SPM_ST_STANDBY = 3'h2,
        SPM_ST_ACTIVE = 3'h4
    } spm_state_t;
endpackage
`default_nettype wire

// [rtl/spm_sync.sv]
// three-stage synchroniser with agreement filter on stages two and three
// assumes async_in is quasi-static relative to the 4 ns clock
`default_nettype none
module spm_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } spm_sync_st_t;

    spm_sync_st_t st_ff;
    spm_sync_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < int'(W); i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.lvl[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.lvl;
endmodule
`default_nettype wire

// [rtl/spm_pin_mux.sv]
// pin function mux for a multi-width serial flash interface, device side
// assumes a command decoder supplies width and transmit data; pins come in async
//
// Summary of operation
// - reset pin held low aborts activity, reinitialises, returns to standby.
// - line 0 is serial input in single mode, data line 0 otherwise.
// - line 1 is serial output in single mode, data line 1 otherwise.
// - line 2 is write-protect input unless quad enable or four-wire mode, then data line 2.
// - line 3 is data line 3 while selected and quad or four-wire mode set.
// - inputs captured on rising clock edge; outputs change after falling edge.
// - deselected: inputs ignored, outputs released; select edge needed after reset.
// - line 3 reset needs select high and line low for reset pulse time.
// - write-protect low with protect bit set silently blocks register writes.
`default_nettype none
module spm_pin_mux
    import spm_pkg::*;
#(
    parameter int unsigned RP_CYCLES = RP_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic data_line_0_in,
    output logic data_line_0_out,
    output logic data_line_0_oe,
    input wire logic data_line_1_in,
    output logic data_line_1_out,
    output logic data_line_1_oe,
    input wire logic data_line_2_in,
    output logic data_line_2_out,
    output logic data_line_2_oe,
    input wire logic data_line_3_in,
    output logic data_line_3_out,
    output logic data_line_3_oe,
    input wire logic [7:0] config1_volatile,
    input wire logic [7:0] config2_volatile,
    input wire logic [7:0] status1_nonvolatile,
    input wire logic [1:0] xfer_width,
    input wire logic tx_enable,
    input wire logic [3:0] tx_bits,
    output logic [3:0] rx_bits,
    output logic rx_valid,
    output logic write_regs_blocked,
    output logic device_reset,
    output logic standby,
    output logic line3_reset_role
);
    localparam int unsigned CNT_W = $clog2(RP_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(RP_CYCLES);

    typedef struct packed {
        spm_state_t state;
        logic sck_prev;
        logic armed;
        logic [CNT_W-1:0] rp_cnt;
        logic [3:0] rx_bits;
        logic rx_valid;
        logic [3:0] dl_out;
        logic [3:0] dl_oe;
        logic wp_block;
        logic dev_reset;
        logic standby;
        logic io3_rst_role;
    } spm_st_t;

    localparam spm_st_t ST_RST = '{
        state: SPM_ST_RESET, sck_prev: 1'b0, armed: 1'b0, rp_cnt: '0,
        rx_bits: 4'h0, rx_valid: 1'b0, dl_out: 4'h0, dl_oe: 4'h0,
        wp_block: 1'b0, dev_reset: 1'b1, standby: 1'b0, io3_rst_role: 1'b0
    };

    spm_st_t st_ff;
    spm_st_t nxt_st;
    logic [PIN_W-1:0] pins;

    spm_sync #(
        .W(PIN_W),
        .RST_VAL(PIN_IDLE)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({reset_pin_n, chip_select_n, serial_clock, data_line_3_in,
                   data_line_2_in, data_line_1_in, data_line_0_in}),
        .level(pins)
    );

    // lines sampled as data for the current width
    function automatic logic [3:0] rx_map(input logic [1:0] w, input logic four, input logic [3:0] d);
        logic [3:0] r;
        r = 4'h0;
        unique case (w)
            SPM_W_DUAL: r = {2'h0, d[1:0]};
            SPM_W_QUAD: r = four ? d : {2'h0, d[1:0]};
            default: r = {3'h0, d[0]};
        endcase
        return r;
    endfunction

    // drive enables and levels for the current width
    function automatic logic [7:0] tx_map(input logic [1:0] w, input logic four, input logic [3:0] t);
        logic [7:0] r;
        r = 8'h00;
        unique case (w)
            SPM_W_DUAL: r = {OE_DUAL, 2'h0, t[1:0]};
            SPM_W_QUAD: r = four ? {OE_QUAD, t} : {OE_DUAL, 2'h0, t[1:0]};
            default: r = {OE_SINGLE, 2'h0, t[0], 1'b0};
        endcase
        return r;
    endfunction

    logic cs_high;
    logic sck_now;
    logic [3:0] dl;
    logic quad_on;
    logic four_on;
    logic io3_role;
    logic rst_req;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] tx_sel;

    always_comb begin
        cs_high = pins[PIN_CS_N];
        sck_now = pins[PIN_SCK];
        dl = pins[3:0];
        quad_on = config1_volatile[CFG1_QUAD_BIT];
        four_on = quad_on | config2_volatile[CFG2_FOUR_WIRE_BIT];
        io3_role = config2_volatile[CFG2_RST_EN_BIT] & (~four_on | cs_high);
        rst_req = ~pins[PIN_RST_N] | (io3_role & cs_high & ~dl[3]);
        sck_rise = sck_now & ~st_ff.sck_prev;
        sck_fall = ~sck_now & st_ff.sck_prev;
        tx_sel = tx_map(xfer_width, four_on, tx_bits);

        nxt_st = st_ff;
        nxt_st.sck_prev = sck_now;
        nxt_st.rx_valid = 1'b0;
        nxt_st.io3_rst_role = io3_role;
        // write-protect only meaningful while line 2 is not a data line
        nxt_st.wp_block = ~dl[2] & status1_nonvolatile[STAT1_PROTECT0_BIT] & ~four_on;

        // low time qualification for both reset sources
        if (!rst_req) begin
            nxt_st.rp_cnt = '0;
        end else if (st_ff.rp_cnt != CNT_MAX) begin
            nxt_st.rp_cnt = st_ff.rp_cnt + CNT_W'(1);
        end

        unique case (st_ff.state)
            SPM_ST_RESET: begin
                nxt_st.dl_oe = 4'h0;
                nxt_st.armed = 1'b0;
                if (!rst_req) begin
                    nxt_st.state = SPM_ST_STANDBY;
                end
            end
            SPM_ST_STANDBY: begin
                nxt_st.dl_oe = 4'h0;
                if (cs_high) begin
                    nxt_st.armed = 1'b1;
                end else if (st_ff.armed) begin
                    nxt_st.state = SPM_ST_ACTIVE;
                end
            end
            SPM_ST_ACTIVE: begin
                if (cs_high) begin
                    nxt_st.state = SPM_ST_STANDBY;
                    nxt_st.dl_oe = 4'h0;
                end else begin
                    if (sck_rise) begin
                        nxt_st.rx_bits = rx_map(xfer_width, four_on, dl);
                        nxt_st.rx_valid = 1'b1;
                    end
                    if (sck_fall) begin
                        nxt_st.dl_out = tx_sel[3:0];
                        nxt_st.dl_oe = tx_enable ? tx_sel[7:4] : 4'h0;
                    end
                end
            end
            default: begin
                nxt_st.state = SPM_ST_RESET;
                nxt_st.dl_oe = 4'h0;
            end
        endcase

        // drop drivers that a width or mode change has taken away
        nxt_st.dl_oe = nxt_st.dl_oe & tx_sel[7:4];

        if (rst_req && st_ff.rp_cnt == CNT_MAX) begin
            nxt_st.state = SPM_ST_RESET;
            nxt_st.dl_oe = 4'h0;
            nxt_st.armed = 1'b0;
        end

        nxt_st.dev_reset = (nxt_st.state == SPM_ST_RESET);
        nxt_st.standby = (nxt_st.state == SPM_ST_STANDBY);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign data_line_0_out = st_ff.dl_out[0];
    assign data_line_0_oe = st_ff.dl_oe[0];
    assign data_line_1_out = st_ff.dl_out[1];
    assign data_line_1_oe = st_ff.dl_oe[1];
    assign data_line_2_out = st_ff.dl_out[2];
    assign data_line_2_oe = st_ff.dl_oe[2];
    assign data_line_3_out = st_ff.dl_out[3];
    assign data_line_3_oe = st_ff.dl_oe[3];
    assign rx_bits = st_ff.rx_bits;
    assign rx_valid = st_ff.rx_valid;
    assign write_regs_blocked = st_ff.wp_block;
    assign device_reset = st_ff.dev_reset;
    assign standby = st_ff.standby;
    assign line3_reset_role = st_ff.io3_rst_role;
endmodule
`default_nettype wire

// [test/spm_host.sv]
// host-side serial controller model: clock, select and data levels
// assumes the bench sequences it through step
`default_nettype none
module spm_host (
    input wire logic clock,
    output logic sck,
    output logic cs_n,
    output logic [3:0] hd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck = 1'b1;
        cs_n = 1'b1;
        hd = 4'hF;
    end
    // data set with each clock move, held for a half period
    task step(input logic s, input logic c, input logic [3:0] d);
        @(posedge clock);
        sck <= s;
        cs_n <= c;
        hd <= d;
        repeat (19) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// [test/spm_pin_mux_monitor.sv]
// port checker for the pin function mux
// assumes it is bound to spm_pin_mux
`default_nettype none
module spm_pin_mux_monitor
    import spm_pkg::*;
#(
    parameter int unsigned RP_CYCLES = RP_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic chip_select_n,
    input wire logic [7:0] config1_volatile,
    input wire logic [7:0] config2_volatile,
    input wire logic [7:0] status1_nonvolatile,
    input wire logic [1:0] xfer_width,
    input wire logic data_line_0_oe,
    input wire logic data_line_1_oe,
    input wire logic data_line_2_oe,
    input wire logic data_line_3_oe,
    input wire logic rx_valid,
    input wire logic write_regs_blocked,
    input wire logic device_reset,
    input wire logic standby,
    input wire logic line3_reset_role
);
    logic [7:0] low_cnt_ff;
    logic [7:0] nxt_low_cnt;
    logic [3:0] oe;
    assign oe = {data_line_3_oe, data_line_2_oe, data_line_1_oe, data_line_0_oe};
    assign nxt_low_cnt = (sys_rst || reset_pin_n) ? 8'h00 : low_cnt_ff + {7'h00, low_cnt_ff != 8'hFF};
    always_ff @(posedge clock) begin
        low_cnt_ff <= nxt_low_cnt;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_cs_high;
        chip_select_n [*8];
    endsequence
    sequence s_no_quad;
        (!config1_volatile[CFG1_QUAD_BIT] && !config2_volatile[CFG2_FOUR_WIRE_BIT]) [*2];
    endsequence
    AST_CS_RELEASE: assert property (s_cs_high |-> oe == 4'h0)
        else $error("outputs driven while deselected");
    AST_LINE2_WP: assert property (s_no_quad |-> !data_line_2_oe)
        else $error("line 2 driven outside quad");
    AST_LINE3_OE: assert property (s_no_quad |-> !data_line_3_oe)
        else $error("line 3 driven outside quad");
    AST_LINE0_SINGLE: assert property ((xfer_width == 2'h0) [*8] |-> !data_line_0_oe)
        else $error("line 0 driven in single mode");
    AST_ROLE_EN: assert property (!config2_volatile[CFG2_RST_EN_BIT] [*2] |-> !line3_reset_role)
        else $error("line 3 reset role without enable");
    AST_WP_BLOCK: assert property (!status1_nonvolatile[STAT1_PROTECT0_BIT] [*2] |-> !write_regs_blocked)
        else $error("writes blocked without protect bit");
    AST_PIN_RESET: assert property (int'(low_cnt_ff) == RP_CYCLES + 6 |-> device_reset)
        else $error("held reset pin not honoured");
    AST_RESET_QUIET: assert property (device_reset [*2] |-> oe == 4'h0 && !standby)
        else $error("pins driven in reset");
    AST_RX_PULSE: assert property (rx_valid |-> !standby ##1 !rx_valid)
        else $error("capture pulse too long or idle");
endmodule
bind spm_pin_mux spm_pin_mux_monitor #(.RP_CYCLES(RP_CYCLES)) u_mon (
    .clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .chip_select_n(chip_select_n),
    .config1_volatile(config1_volatile), .config2_volatile(config2_volatile),
    .status1_nonvolatile(status1_nonvolatile), .xfer_width(xfer_width),
    .data_line_0_oe(data_line_0_oe), .data_line_1_oe(data_line_1_oe), .data_line_2_oe(data_line_2_oe),
    .data_line_3_oe(data_line_3_oe), .rx_valid(rx_valid), .write_regs_blocked(write_regs_blocked),
    .device_reset(device_reset), .standby(standby), .line3_reset_role(line3_reset_role));
`default_nettype wire

// [test/spm_pin_mux_tb.sv]
// self-checking bench for the pin function mux
// assumes spm_host as the far side and a 4 ns clock
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", n, e, a); end end
module spm_pin_mux_tb;
    import spm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // {quad, four_wire, width} oe mask, rx mask
    localparam logic [11:0] TBL [6] = '{12'h021, 12'h133, 12'h233, 12'hAFF, 12'h6FF, 12'h321};
    logic clock, sys_rst, rpn, te, rv, blk, dr, sb, role, sck, csn;
    logic [7:0] c1, c2, st;
    logic [1:0] xw;
    logic [3:0] tx, o, oe, rx, hd, pin, v;
    int mismatches = 0;
    int n_checks = 0;
    int n_rx = 0;
    // counts capture pulses of the design
    always @(posedge clock) begin
        if (rv === 1'b1) begin
            n_rx++;
        end
    end
    assign pin = (oe & o) | (~oe & hd);
    spm_host h (.clock(clock), .sck(sck), .cs_n(csn), .hd(hd));
    spm_pin_mux #(.RP_CYCLES(4)) u_dut (.clock(clock), .sys_rst(sys_rst), .reset_pin_n(rpn),
        .serial_clock(sck), .chip_select_n(csn), .data_line_0_in(pin[0]), .data_line_0_out(o[0]),
        .data_line_0_oe(oe[0]), .data_line_1_in(pin[1]), .data_line_1_out(o[1]), .data_line_1_oe(oe[1]),
        .data_line_2_in(pin[2]), .data_line_2_out(o[2]), .data_line_2_oe(oe[2]), .data_line_3_in(pin[3]),
        .data_line_3_out(o[3]), .data_line_3_oe(oe[3]), .config1_volatile(c1), .config2_volatile(c2),
        .status1_nonvolatile(st), .xfer_width(xw), .tx_enable(te), .tx_bits(tx), .rx_bits(rx),
        .rx_valid(rv), .write_regs_blocked(blk), .device_reset(dr), .standby(sb), .line3_reset_role(role));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task w(input int n);
        repeat (n) @(posedge clock);
    endtask
    initial begin
        #50us;
        mismatches++;
        end_sim();
    end
    initial begin
        sys_rst = 1'b1; rpn = 1'b1; c1 = 8'h00; c2 = 8'h00; st = 8'h00; xw = 2'h0; te = 1'b1; tx = 4'h5;
        w(4);
        sys_rst <= 1'b0;
        w(8);
        `CHK("standby", 1'b1, sb)
        `CHK("idle oe", 4'h0, oe)
        $display("TEST reset done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clock);
            c1 <= {6'h00, TBL[i][11], 1'h0};
            c2 <= {4'h0, TBL[i][10], 3'h0};
            xw <= TBL[i][9:8];
            h.step(1'b1, 1'b0, 4'hF);
            h.step(1'b0, 1'b0, 4'hB);
            `CHK("oe", TBL[i][7:4], oe)
            // single width sends its lone bit on line 1
            v = (TBL[i][7:4] == 4'h2) ? 4'h2 : (TBL[i][7:4] & 4'h5);
            `CHK("out", v, o & oe)
            v = v | (~TBL[i][7:4] & 4'hB);
            h.step(1'b1, 1'b0, 4'hB);
            `CHK("rx", v & TBL[i][3:0], rx)
            h.step(1'b1, 1'b1, 4'hF);
            `CHK("released", 4'h0, oe)
        end
        $display("TEST widths done");
        te <= 1'b0;
        h.step(1'b1, 1'b0, 4'hF);
        h.step(1'b0, 1'b0, 4'hF);
        `CHK("no tx oe", 4'h0, oe)
        h.step(1'b1, 1'b1, 4'hF);
        `CHK("rx pulses", 6, n_rx)
        $display("TEST no drive done");
        @(posedge clock);
        c1 <= 8'h00;
        c2 <= 8'h00;
        st <= 8'h80;
        h.step(1'b1, 1'b1, 4'hB);
        `CHK("blocked", 1'b1, blk)
        h.step(1'b1, 1'b1, 4'hF);
        `CHK("unblocked", 1'b0, blk)
        c1 <= 8'h02;
        h.step(1'b1, 1'b1, 4'hB);
        `CHK("quad wp", 1'b0, blk)
        $display("TEST protect done");
        c1 <= 8'h00;
        c2 <= 8'h80;
        st <= 8'h00;
        h.step(1'b1, 1'b1, 4'hF);
        `CHK("role", 1'b1, role)
        h.step(1'b1, 1'b1, 4'h7);
        `CHK("l3 reset", 1'b1, dr)
        h.step(1'b1, 1'b1, 4'hF);
        `CHK("l3 back", 1'b1, sb)
        c1 <= 8'h02;
        h.step(1'b1, 1'b0, 4'h7);
        `CHK("quad role", 1'b0, role)
        `CHK("no l3 reset", 1'b0, dr)
        h.step(1'b1, 1'b1, 4'hF);
        `CHK("desel role", 1'b1, role)
        $display("TEST line3 done");
        c2 <= 8'h00;
        rpn <= 1'b0;
        w(2);
        rpn <= 1'b1;
        w(12);
        `CHK("short pulse", 1'b0, dr)
        h.step(1'b1, 1'b0, 4'hF);
        rpn <= 1'b0;
        w(14);
        `CHK("pin reset", 1'b1, dr)
        rpn <= 1'b1;
        w(12);
        `CHK("re-arm", 1'b1, sb)
        h.step(1'b1, 1'b1, 4'hF);
        $display("TEST pin reset done");
        end_sim();
    end
endmodule
`default_nettype wire
